// ---- rtl/cem_mac.sv ----
// Half-duplex CSMA/CD Ethernet media access controller with octet-wide medium ports.
`timescale 1ns/1ns

module cem_mac (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic [47:0] i_station_addr,
   input wire logic i_promisc,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   input wire logic i_crs,
   input wire logic i_col,
   input wire logic i_rx_dv,
   input wire logic [7:0] i_rx_data,
   output logic o_tx_ready,
   output logic o_tx_en,
   output logic [7:0] o_tx_data,
   output logic o_tx_done,
   output logic o_tx_retry,
   output logic o_tx_excess,
   output logic o_tx_len_err,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic o_rx_end,
   output logic o_rx_crc_err,
   output logic o_rx_len_err,
   output logic o_rx_accept,
   output cem_pkg::cem_kind_t o_rx_kind
);
   import cem_pkg::*;

   cem_tx_state_t tx_st_q;
   cem_rx_state_t rx_st_q;
   logic [3:0] idle_cnt_q;
   logic [15:0] lfsr_q, rx_lt_q;
   logic [10:0] tx_cnt_q, rx_cnt_q;
   logic [1:0] fcs_idx_q;
   logic [2:0] jam_cnt_q;
   logic [4:0] attempts_q, next_attempt;
   logic [9:0] slots_q;
   logic [5:0] slot_sub_q;
   logic [31:0] tx_crc_q, rx_crc_q;
   logic [7:0] tx_data_q, rx_data_q;
   logic [47:0] rx_da_q;
   logic tx_ready_q, tx_en_q, tx_done_q, tx_retry_q, tx_excess_q, tx_len_err_q;
   logic rx_valid_q, rx_end_q, rx_crc_err_q, rx_len_err_q, rx_accept_q;
   logic medium_idle, sending, rx_len_bad;
   cem_kind_t rx_kind_q;

   // One octet step of the reflected Ethernet CRC, least significant bit first.
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] octet);
      for (int i = 0; i < 8; i++)
         crc = (crc[0] ^ octet[i]) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
      return crc;
   endfunction

   // Mask that limits the random slot count to the set of the given round.
   function automatic logic [9:0] backoff_mask(input logic [4:0] round);
      return 10'((11'h001 << ((round > BACKOFF_CAP) ? BACKOFF_CAP : round)) - 11'h001);
   endfunction

   // Sorts the length/type field into a length, a known protocol or other.
   function automatic cem_kind_t classify(input logic [15:0] lt);
      if (lt <= LEN_FIELD_MAX)
         return KIND_LEN;
      if (lt == TYPE_IP)
         return KIND_IP;
      if (lt == TYPE_LOOP)
         return KIND_LOOP;
      if (lt == TYPE_NET)
         return KIND_NET;
      return KIND_OTHER;
   endfunction

   assign medium_idle = (idle_cnt_q == IFG_OCTETS) && !i_crs;
   assign sending = tx_en_q && (tx_st_q != TX_JAM);
   assign next_attempt = attempts_q + 5'h01;
   assign rx_len_bad = (rx_cnt_q < MIN_FRAME) || (rx_cnt_q > MAX_FRAME);

   // Counts idle octet times; own or foreign carrier restarts the gap.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         idle_cnt_q <= 4'h0;
      else if (i_ce)
      begin
         if (i_crs || tx_en_q)
            idle_cnt_q <= 4'h0;
         else if (idle_cnt_q != IFG_OCTETS)
            idle_cnt_q <= idle_cnt_q + 4'h1;
      end
   end

   // Free-running pseudo-random source for the backoff draw.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         lfsr_q <= LFSR_SEED;
      else if (i_ce)
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
   end

   // Transmit sequencer: deferral, framing, collision handling and backoff.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         tx_st_q <= TX_IDLE;
         tx_cnt_q <= 11'h000;
         fcs_idx_q <= 2'h0;
         jam_cnt_q <= 3'h0;
         attempts_q <= 5'h00;
         slots_q <= 10'h000;
         slot_sub_q <= 6'h00;
         tx_crc_q <= CRC_INIT;
         tx_data_q <= 8'h00;
         {tx_ready_q, tx_en_q, tx_done_q, tx_retry_q, tx_excess_q, tx_len_err_q} <= 6'h00;
      end
      else if (i_ce)
      begin
         {tx_done_q, tx_retry_q, tx_excess_q, tx_len_err_q} <= 4'h0;
         if (sending && i_col)
         begin
            tx_st_q <= TX_JAM;
            tx_ready_q <= 1'b0;
            tx_data_q <= JAM_BYTE;
            jam_cnt_q <= 3'h0;
         end
         else
         begin
            case (tx_st_q)
               TX_IDLE:
               begin
                  attempts_q <= 5'h00;
                  if (i_tx_valid)
                     tx_st_q <= TX_DEFER;
               end
               TX_DEFER:
               begin
                  if (medium_idle)
                  begin
                     tx_st_q <= TX_PRE;
                     tx_cnt_q <= 11'h000;
                  end
               end
               TX_PRE:
               begin
                  tx_en_q <= 1'b1;
                  tx_data_q <= PRE_BYTE;
                  tx_cnt_q <= tx_cnt_q + 11'h001;
                  if (tx_cnt_q == 11'(PRE_OCTETS - 4'h1))
                     tx_st_q <= TX_SFD;
               end
               TX_SFD:
               begin
                  tx_data_q <= SFD_BYTE;
                  tx_cnt_q <= 11'h000;
                  tx_crc_q <= CRC_INIT;
                  tx_ready_q <= 1'b1;
                  tx_st_q <= TX_DATA;
               end
               TX_DATA:
               begin
                  if (!i_tx_valid)
                  begin
                     tx_en_q <= 1'b0;
                     tx_ready_q <= 1'b0;
                     tx_len_err_q <= 1'b1;
                     tx_st_q <= TX_IDLE;
                  end
                  else
                  begin
                     // Host supplies address, length/type and payload in order.
                     tx_data_q <= i_tx_data;
                     tx_crc_q <= crc_step(tx_crc_q, i_tx_data);
                     tx_cnt_q <= tx_cnt_q + 11'h001;
                     if (i_tx_last)
                     begin
                        tx_ready_q <= 1'b0;
                        fcs_idx_q <= 2'h0;
                        tx_st_q <= (tx_cnt_q + 11'h001 < MIN_DATA) ? TX_PAD : TX_FCS;
                     end
                     else if (tx_cnt_q == MAX_DATA - 11'h001)
                     begin
                        tx_ready_q <= 1'b0;
                        tx_en_q <= 1'b0;
                        tx_len_err_q <= 1'b1;
                        tx_st_q <= TX_IDLE;
                     end
                  end
               end
               TX_PAD:
               begin
                  tx_data_q <= PAD_BYTE;
                  tx_crc_q <= crc_step(tx_crc_q, PAD_BYTE);
                  tx_cnt_q <= tx_cnt_q + 11'h001;
                  if (tx_cnt_q == MIN_DATA - 11'h001)
                     tx_st_q <= TX_FCS;
               end
               TX_FCS:
               begin
                  tx_data_q <= ~tx_crc_q[8 * fcs_idx_q +: 8];
                  fcs_idx_q <= fcs_idx_q + 2'h1;
                  if (fcs_idx_q == FCS_LAST)
                     tx_st_q <= TX_END;
               end
               TX_END:
               begin
                  tx_en_q <= 1'b0;
                  tx_done_q <= 1'b1;
                  tx_st_q <= TX_IDLE;
               end
               TX_JAM:
               begin
                  if (jam_cnt_q == JAM_LAST)
                  begin
                     tx_en_q <= 1'b0;
                     attempts_q <= next_attempt;
                     if (next_attempt == MAX_ATTEMPTS)
                     begin
                        tx_excess_q <= 1'b1;
                        tx_st_q <= TX_IDLE;
                     end
                     else
                     begin
                        tx_retry_q <= 1'b1;
                        slots_q <= lfsr_q[9:0] & backoff_mask(next_attempt);
                        slot_sub_q <= 6'h00;
                        tx_st_q <= TX_BACKOFF;
                     end
                  end
                  else
                  begin
                     tx_data_q <= JAM_BYTE;
                     jam_cnt_q <= jam_cnt_q + 3'h1;
                  end
               end
               TX_BACKOFF:
               begin
                  if (slots_q == 10'h000)
                     tx_st_q <= TX_DEFER;
                  else if (slot_sub_q == SLOT_LAST)
                  begin
                     slot_sub_q <= 6'h00;
                     slots_q <= slots_q - 10'h001;
                  end
                  else
                     slot_sub_q <= slot_sub_q + 6'h01;
               end
               default:
               begin
                  tx_st_q <= TX_IDLE;
                  tx_en_q <= 1'b0;
                  tx_ready_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Receive sequencer: every frame on the segment is framed and checked.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rx_st_q <= RX_IDLE;
         rx_cnt_q <= 11'h000;
         rx_crc_q <= CRC_INIT;
         rx_da_q <= 48'h000000000000;
         rx_lt_q <= 16'h0000;
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
      end
      else if (i_ce)
      begin
         rx_valid_q <= 1'b0;
         case (rx_st_q)
            RX_IDLE, RX_PRE:
            begin
               if (!i_rx_dv)
                  rx_st_q <= RX_IDLE;
               else if (i_rx_data == SFD_BYTE)
               begin
                  rx_st_q <= RX_BODY;
                  rx_cnt_q <= 11'h000;
                  rx_crc_q <= CRC_INIT;
               end
               else
                  rx_st_q <= RX_PRE;
            end
            RX_BODY:
            begin
               if (!i_rx_dv)
                  rx_st_q <= RX_IDLE;
               else
               begin
                  rx_valid_q <= 1'b1;
                  rx_data_q <= i_rx_data;
                  rx_crc_q <= crc_step(rx_crc_q, i_rx_data);
                  if (rx_cnt_q != 11'h7ff)
                     rx_cnt_q <= rx_cnt_q + 11'h001;
                  if (rx_cnt_q < 11'(ADDR_OCTETS))
                     rx_da_q <= {rx_da_q[39:0], i_rx_data};
                  if (rx_cnt_q == LT_FIRST || rx_cnt_q == LT_SECOND)
                     rx_lt_q <= {rx_lt_q[7:0], i_rx_data};
               end
            end
            default:
               rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // Frame-end report: check sequence, length bounds, acceptance and type.
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         {rx_end_q, rx_crc_err_q, rx_len_err_q, rx_accept_q} <= 4'h0;
         rx_kind_q <= KIND_LEN;
      end
      else if (i_ce)
      begin
         rx_end_q <= 1'b0;
         if (rx_st_q == RX_BODY && !i_rx_dv)
         begin
            rx_end_q <= 1'b1;
            rx_crc_err_q <= (rx_crc_q != CRC_RESIDUE);
            rx_len_err_q <= rx_len_bad;
            rx_accept_q <= !rx_len_bad && (rx_crc_q == CRC_RESIDUE) &&
               (i_promisc || rx_da_q == i_station_addr || rx_da_q == BCAST_ADDR);
            rx_kind_q <= classify(rx_lt_q);
         end
      end
   end

   assign {o_tx_ready, o_tx_en, o_tx_done, o_tx_retry} = {tx_ready_q, tx_en_q, tx_done_q, tx_retry_q};
   assign {o_tx_excess, o_tx_len_err, o_rx_valid, o_rx_end} = {tx_excess_q, tx_len_err_q, rx_valid_q, rx_end_q};
   assign {o_rx_crc_err, o_rx_len_err, o_rx_accept} = {rx_crc_err_q, rx_len_err_q, rx_accept_q};
   assign o_tx_data = tx_data_q;
   assign o_rx_data = rx_data_q;
   assign o_rx_kind = rx_kind_q;

endmodule // cem_mac

// ---- rtl/cem_pkg.sv ----
// Constants and types shared by the half-duplex Ethernet media access controller.
package cem_pkg;

   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hd5;
   localparam logic [7:0] JAM_BYTE = 8'h55;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam logic [3:0] PRE_OCTETS = 4'h7;
   localparam logic [3:0] ADDR_OCTETS = 4'h6;
   localparam logic [10:0] LT_FIRST = 11'h00c;
   localparam logic [10:0] LT_SECOND = 11'h00d;
   localparam logic [1:0] FCS_LAST = 2'h3;
   localparam logic [2:0] JAM_LAST = 3'h3;
   localparam logic [10:0] MIN_FRAME = 11'h040;
   localparam logic [10:0] MAX_FRAME = 11'h5ee;
   localparam logic [10:0] MIN_DATA = 11'h03c;
   localparam logic [10:0] MAX_DATA = 11'h5ea;
   localparam logic [3:0] IFG_OCTETS = 4'hc;
   localparam logic [5:0] SLOT_LAST = 6'h3f;
   localparam logic [4:0] BACKOFF_CAP = 5'h0a;
   localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] TYPE_IP = 16'h0800;
   localparam logic [15:0] TYPE_LOOP = 16'h9000;
   localparam logic [15:0] TYPE_NET = 16'h0600;
   localparam logic [15:0] LEN_FIELD_MAX = 16'h05dc;
   localparam logic [47:0] BCAST_ADDR = 48'hffffffffffff;

   typedef enum logic [2:0] {KIND_LEN, KIND_IP, KIND_LOOP, KIND_NET, KIND_OTHER} cem_kind_t;
   typedef enum {TX_IDLE, TX_DEFER, TX_PRE, TX_SFD, TX_DATA, TX_PAD, TX_FCS, TX_END, TX_JAM,
      TX_BACKOFF} cem_tx_state_t;
   typedef enum {RX_IDLE, RX_PRE, RX_BODY} cem_rx_state_t;

endpackage

// ---- tb/cem_mac_monitor.sv ----
// Assertion checker bound to the ports of the media access controller.
`timescale 1ns/1ns
module cem_mac_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_crs,
   input wire logic i_col,
   input wire logic i_rx_dv,
   input wire logic [7:0] i_rx_data,
   input wire logic o_tx_ready,
   input wire logic o_tx_en,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_done,
   input wire logic o_tx_retry,
   input wire logic o_tx_excess,
   input wire logic o_rx_valid,
   input wire logic [7:0] o_rx_data,
   input wire logic o_rx_end,
   input wire logic o_rx_crc_err,
   input wire logic o_rx_len_err,
   input wire logic o_rx_accept
);
   import cem_pkg::*;
   int idle_q;
   int len_q;
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         idle_q <= 0;
      else if (o_tx_en || i_crs)
         idle_q <= 0;
      else if (idle_q < 20)
         idle_q <= idle_q + 1;
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         len_q <= 0;
      else if (o_tx_en)
         len_q <= len_q + 1;
      else
         len_q <= 0;
   end
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   sequence s_preamble;
      (o_tx_en && o_tx_data == PRE_BYTE) [*7];
   endsequence
   sequence s_delim;
      o_tx_en && o_tx_data == SFD_BYTE;
   endsequence
   a_preamble_then_sfd: assert property ($rose(o_tx_en) |-> s_preamble ##1 s_delim)
      else $error("preamble or delimiter wrong");
   a_sense_idle: assert property ($rose(o_tx_en) |-> !$past(i_crs))
      else $error("send started on busy medium");
   a_idle_gap: assert property ($rose(o_tx_en) |-> idle_q >= 11)
      else $error("idle gap too short");
   a_col_abort: assert property (o_tx_en && i_col |=> !o_tx_ready ##[0:4] !o_tx_en)
      else $error("collision not aborted");
   a_retry_after_jam: assert property (o_tx_retry |-> $fell(o_tx_en) && $past(o_tx_data) == JAM_BYTE)
      else $error("retry without jam");
   a_backoff_quiet: assert property (o_tx_retry |-> !o_tx_en [*8])
      else $error("resent without waiting");
   a_frame_length: assert property (o_tx_done |-> len_q >= 72 && len_q <= 1526)
      else $error("sent frame length out of range");
   a_excess_drop: assert property (o_tx_excess |-> $fell(o_tx_en) && !o_tx_retry ##1 !o_tx_en)
      else $error("excess pulse wrong");
   a_rx_echo: assert property (o_rx_valid |-> $past(i_rx_dv) && o_rx_data == $past(i_rx_data))
      else $error("received octet not passed on");
   a_rx_body_start: assert property ($rose(o_rx_valid) |-> $past(i_rx_data, 2) == SFD_BYTE)
      else $error("body did not follow delimiter");
   a_rx_end_mark: assert property (o_rx_end |-> !$past(i_rx_dv) && $past(i_rx_dv, 2))
      else $error("frame end misplaced");
   a_accept_clean: assert property (o_rx_end && o_rx_accept |-> !o_rx_crc_err && !o_rx_len_err)
      else $error("bad frame accepted");
endmodule // cem_mac_monitor

bind cem_mac cem_mac_monitor cem_mac_monitor_inst (.i_clk_sys, .i_rstn, .i_crs, .i_col, .i_rx_dv, .i_rx_data,
   .o_tx_ready, .o_tx_en, .o_tx_data, .o_tx_done, .o_tx_retry, .o_tx_excess, .o_rx_valid, .o_rx_data, .o_rx_end,
   .o_rx_crc_err, .o_rx_len_err, .o_rx_accept);

// ---- tb/cem_station.sv ----
// Model of another station on the shared medium.
`timescale 1ns/1ns
module cem_station (
   input wire logic i_clk_sys,
   output logic o_crs,
   output logic o_col,
   output logic o_dv,
   output logic [7:0] o_data
);
   import cem_pkg::*;
   logic [7:0] fr [0:1599];
   initial
   begin
      o_crs = 1'b0;
      o_col = 1'b0;
      o_dv = 1'b0;
      o_data = 8'h00;
   end
   function automatic logic [31:0] crc_of(input int n);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = 0; i < n; i++)
      begin
         c = c ^ {24'h000000, fr[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction
   // Modes: 0 idle, 1 carrier, 2 collision, 3 frame octet; idle data toggles.
   task automatic step(input int mode, input logic [7:0] b);
      @(negedge i_clk_sys);
      o_dv = mode == 3;
      o_crs = mode != 0;
      o_col = mode == 2;
      o_data = mode == 3 ? b : ~o_data;
   endtask
   task automatic busy(input int n, input logic col);
      repeat (n) step(col ? 2 : 1, 8'h00);
      step(0, 8'h00);
   endtask
   task automatic send(input int n, input logic bad);
      logic [31:0] f;
      f = crc_of(n) ^ {31'h0, bad};
      repeat (PRE_OCTETS) step(3, PRE_BYTE);
      step(3, SFD_BYTE);
      for (int i = 0; i < n; i++)
         step(3, fr[i]);
      for (int i = 0; i < 4; i++)
         step(3, f[8 * i +: 8]);
      repeat (IFG_OCTETS) step(0, 8'h00);
   endtask
endmodule // cem_station

// ---- tb/tb.sv ----
// Self-checking testbench for the media access controller.
`timescale 1ns/1ns
module tb;
   import cem_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic i_promisc = 1'b0;
   logic i_tx_valid = 1'b0;
   logic i_tx_last = 1'b0;
   logic [7:0] i_tx_data = 8'h00;
   logic [47:0] i_station_addr = 48'h0a1b2c3d4e5f;
   logic i_crs, i_col, i_rx_dv;
   logic [7:0] i_rx_data, o_tx_data, o_rx_data;
   logic o_tx_ready, o_tx_en, o_tx_done, o_tx_retry, o_tx_excess, o_tx_len_err;
   logic o_rx_valid, o_rx_end, o_rx_crc_err, o_rx_len_err, o_rx_accept;
   cem_kind_t o_rx_kind;
   logic [7:0] txq[$], rxq[$];
   int seed = 32'h567f191c;
   int errors = 0, num_checks = 0, cyc = 0, tx_idx = 0, tx_len = 0, ends = 0, retries = 0;
   int ns[8] = '{60, 60, 100, 100, 59, 1514, 1515, 60};
   logic [15:0] lts[8] = '{TYPE_IP, TYPE_LOOP, TYPE_NET, TYPE_NET, LEN_FIELD_MAX, 16'h1234, TYPE_IP, TYPE_IP};
   cem_mac cem_mac_inst (.i_clk_sys, .i_rstn, .i_ce(1'b1), .i_station_addr, .i_promisc, .i_tx_valid, .i_tx_data,
      .i_tx_last, .i_crs, .i_col, .i_rx_dv, .i_rx_data, .o_tx_ready, .o_tx_en, .o_tx_data, .o_tx_done, .o_tx_retry,
      .o_tx_excess, .o_tx_len_err, .o_rx_valid, .o_rx_data, .o_rx_end, .o_rx_crc_err, .o_rx_len_err, .o_rx_accept,
      .o_rx_kind);
   cem_station cem_station_inst (.i_clk_sys, .o_crs(i_crs), .o_col(i_col), .o_dv(i_rx_dv), .o_data(i_rx_data));
   always #50 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 1;
      tx_idx <= (!i_tx_valid || o_tx_retry) ? 0 : tx_idx + int'(o_tx_ready);
      if (o_tx_en)
         txq.push_back(o_tx_data);
      if (o_tx_retry)
         txq.delete();
      if (o_tx_retry)
         retries <= retries + 1;
      if (o_rx_valid)
         rxq.push_back(o_rx_data);
      if (o_rx_end)
         ends <= ends + 1;
      if (cyc > 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   always @(negedge i_clk_sys)
   begin
      i_tx_data <= cem_station_inst.fr[tx_idx];
      i_tx_last <= (tx_idx == tx_len - 1);
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic cem_kind_t kind_of(input logic [15:0] lt);
      return lt <= LEN_FIELD_MAX ? KIND_LEN : lt == TYPE_IP ? KIND_IP : lt == TYPE_LOOP ? KIND_LOOP :
         lt == TYPE_NET ? KIND_NET : KIND_OTHER;
   endfunction
   task automatic fill(input int n, input logic [47:0] da, input logic [15:0] lt);
      for (int i = 0; i < 1600; i++)
         cem_station_inst.fr[i] = i < 6 ? da[47 - 8 * i -: 8] : i < 12 ? 8'(i) : i == 12 ? lt[15:8] :
            i == 13 ? lt[7:0] : i < n ? 8'($random(seed)) : PAD_BYTE;
   endtask
   task automatic tx_frame(input int n, input int ncol);
      int m;
      int t0;
      int r0;
      logic [31:0] f;
      m = n < 60 ? 60 : n;
      r0 = retries;
      txq.delete();
      fill(n, 48'h665544332211, TYPE_IP);
      f = cem_station_inst.crc_of(m);
      tx_len = n;
      @(negedge i_clk_sys);
      i_tx_valid = 1'b1;
      for (int c = 0; c < ncol; c++)
      begin
         for (int k = 0; k < 3000 && o_tx_en !== 1'b1; k++)
            @(negedge i_clk_sys);
         repeat (20) @(negedge i_clk_sys);
         cem_station_inst.busy(2, 1'b1);
         cem_station_inst.busy(150, 1'b0);
         chk(retries, r0 + c + 1);
         chk(32'(o_tx_en), 0);
         t0 = cyc;
         for (int k = 0; k < 3000 && o_tx_en !== 1'b1; k++)
            @(negedge i_clk_sys);
         chk(32'(cyc - t0 >= 12), 1);
      end
      for (int k = 0; k < 4000 && o_tx_done !== 1'b1 && o_tx_len_err !== 1'b1; k++)
         @(negedge i_clk_sys);
      i_tx_valid = 1'b0;
      chk(32'(o_tx_done), 32'(n <= 1514));
      chk(32'(o_tx_len_err), 32'(n > 1514));
      if (n <= 1514)
      begin
         chk(32'(txq.size()), 32'(12 + m));
         for (int i = 0; i < 12 + m; i++)
            chk(32'(txq[i]), 32'(i < 7 ? PRE_BYTE : i == 7 ? SFD_BYTE : i < 8 + m ? cem_station_inst.fr[i - 8] :
               f[8 * (i - 8 - m) +: 8]));
      end
   endtask
   task automatic rx_frame(input int n, input logic [47:0] da, input logic [15:0] lt, input logic bad);
      int e;
      logic ok;
      e = ends;
      ok = n >= 60 && n <= 1514;
      fill(n, da, lt);
      rxq.delete();
      cem_station_inst.send(n, bad);
      chk(ends, e + 1);
      chk(32'(rxq.size()), 32'(n + 4));
      for (int i = 0; i < n; i++)
         chk(32'(rxq[i]), 32'(cem_station_inst.fr[i]));
      chk(32'(o_rx_len_err), 32'(!ok));
      chk(32'(o_rx_crc_err), 32'(bad));
      chk(32'(o_rx_accept), 32'(ok && !bad && (da == i_station_addr || da == BCAST_ADDR || i_promisc)));
      chk(32'(o_rx_kind), 32'(kind_of(lt)));
   endtask
   initial
   begin
      repeat (5) @(negedge i_clk_sys);
      i_rstn = 1'b1;
      chk(32'(o_tx_en), 0);
      chk(32'(o_rx_kind), 32'(KIND_LEN));
      tx_frame(20, 0);
      tx_frame(1514, 0);
      for (int i = 0; i < 8; i++)
      begin
         i_promisc = (i == 3);
         rx_frame(ns[i], i == 1 ? BCAST_ADDR : (i == 2 || i == 3) ? 48'h0c0000000001 : i_station_addr, lts[i], i == 7);
      end
      tx_frame(14 + ($random(seed) & 32'h1ff), 2);
      tx_frame(1515, 0);
      give_verdict();
   end
endmodule // tb
